// File: bench/conv_model.sv
// Converter stand-in: answers conversion starts and makes decimation ticks
`timescale 1ns/1ps

module conv_model #(
   parameter TICK_DIV = 2
) (
   input  wire       sys_clk,
   input  wire       rst_n,
   input  wire       conv_start,
   input  wire [7:0] lat,
   output reg        conv_done,
   output reg        decimation_clock_tick
);
   reg [7:0] cnt_q;
   reg [3:0] div_q;

   // A new start restarts the count, so a stale conversion never answers early
   always @(posedge sys_clk) begin
      conv_done <= 1'b0;
      decimation_clock_tick <= 1'b0;
      div_q <= div_q + 4'h1;
      if (!rst_n) begin
         cnt_q <= 8'h00;
         div_q <= 4'h0;
      end else begin
         if (div_q == TICK_DIV - 1) begin
            div_q <= 4'h0;
            decimation_clock_tick <= 1'b1;
         end
         if (conv_start) begin
            cnt_q <= lat;
         end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
            conv_done <= (cnt_q == 8'h01);
         end
      end
   end
endmodule

// File: bench/scan_seq_checker.sv
// Concurrent checks on the scan sequencer ports
`timescale 1ns/1ps
`include "scan_seq_regs.vh"

module scan_seq_checker (
   input wire       sys_clk,
   input wire       rst_n,
   input wire [7:0] mux_code,
   input wire [2:0] gain_code,
   input wire [1:0] adc_mode_int,
   input wire       conv_start,
   input wire       offset_short,
   input wire [3:0] chan_id,
   input wire       scan_busy,
   input wire       warmup_active
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   wire st_sup = conv_start && chan_id == `CH_SUPPLY;

   AST_SUPPLY_MUX: assert property (st_sup |-> mux_code == `MUX_SUPPLY)
      else $error("supply mux code wrong");
   AST_SUPPLY_GAIN: assert property (st_sup |-> gain_code == `GAIN_X033)
      else $error("supply gain wrong");
   AST_TEMP: assert property (conv_start && chan_id == `CH_TEMP
      |-> mux_code == `MUX_TEMP && gain_code == `GAIN_X1) else $error("temp override wrong");
   AST_OFFSET: assert property (conv_start && chan_id == `CH_OFFSET |-> offset_short)
      else $error("offset short missing");
   AST_CM: assert property (conv_start && chan_id == `CH_COMMON_MODE
      |-> mux_code == `MUX_COMMON_MODE && gain_code == `GAIN_X1) else $error("cm override wrong");
   AST_START: assert property (conv_start |-> scan_busy && adc_mode_int == `ADC_CONVERT ##1 !conv_start)
      else $error("start pulse wrong");
   AST_WARM_MODE: assert property (warmup_active |-> adc_mode_int == `ADC_STANDBY)
      else $error("warm-up not in standby");
   AST_WARM_LAUNCH: assert property ($rose(warmup_active) |-> ##[1:600] conv_start)
      else $error("no launch after warm-up");
   AST_SHUT_HOLD: assert property (adc_mode_int == `ADC_SHUTDOWN && scan_busy
      |=> adc_mode_int != `ADC_CONVERT) else $error("convert straight from shutdown");

   cover property (st_sup);
   cover property ($rose(warmup_active));
   cover property (scan_busy && adc_mode_int == `ADC_STANDBY);
endmodule

bind scan_sequencer_timing scan_seq_checker i_scan_seq_checker (.sys_clk(sys_clk), .rst_n(rst_n),
   .mux_code(mux_code), .gain_code(gain_code), .adc_mode_int(adc_mode_int), .conv_start(conv_start),
   .offset_short(offset_short), .chan_id(chan_id), .scan_busy(scan_busy), .warmup_active(warmup_active));

// File: bench/scan_sequencer_timing_test.sv
// Self-checking bench for the scan sequencer
`timescale 1ns/1ps
`include "scan_seq_regs.vh"

module scan_sequencer_timing_test;
   reg         sys_clk;
   reg         rst_n;
   reg         cfg_wr_en;
   reg  [3:0]  cfg_addr;
   reg  [23:0] cfg_wr_data;
   reg  [3:0]  cfg_rd_addr;
   reg  [7:0]  lat;
   reg  [10:0] x;
   wire [23:0] cfg_rd_data;
   wire        tick;
   wire        conv_done;
   wire [7:0]  mux_code;
   wire [2:0]  gain_code;
   wire [1:0]  adc_mode_int;
   wire        conv_start;
   wire        offset_short;
   wire [3:0]  chan_id;
   wire        scan_busy;
   wire        warmup_active;
   integer     error_cnt;
   integer     total_checks;
   integer     n, w, k, g, c, e, iv;

   scan_sequencer_timing i_scan_sequencer_timing (.sys_clk(sys_clk), .rst_n(rst_n), .cfg_wr_en(cfg_wr_en),
      .cfg_addr(cfg_addr), .cfg_wr_data(cfg_wr_data), .cfg_rd_addr(cfg_rd_addr), .cfg_rd_data(cfg_rd_data),
      .decimation_clock_tick(tick), .conv_done(conv_done), .mux_code(mux_code), .gain_code(gain_code),
      .adc_mode_int(adc_mode_int), .conv_start(conv_start), .offset_short(offset_short),
      .chan_id(chan_id), .scan_busy(scan_busy), .warmup_active(warmup_active));
   conv_model i_conv_model (.sys_clk(sys_clk), .rst_n(rst_n), .conv_start(conv_start), .lat(lat),
      .conv_done(conv_done), .decimation_clock_tick(tick));

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   task chk(input [23:0] got, input [23:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task cyc;
      begin
         @(posedge sys_clk);
         #1;
      end
   endtask
   task wr(input [3:0] a, input [23:0] d);
      begin
         cyc;
         cfg_wr_en = 1'b1;
         cfg_addr = a;
         cfg_wr_data = d;
         cyc;
         cfg_wr_en = 1'b0;
      end
   endtask
   task rd(input [3:0] a, input [23:0] d);
      begin
         cfg_rd_addr = a;
         cyc;
         chk(cfg_rd_data, d);
      end
   endtask
   // Tick counts allow one tick of slack for where the count is sampled
   // Callers clear n, and w where warm-up is timed, at the edge where the counted span begins
   task wait_start;
      begin
         for (k = 0; k < 2000 && conv_start !== 1'b1; k = k + 1) begin
            if (tick === 1'b1) n = n + 1;
            if (warmup_active === 1'b1 && w < 0) w = n;
            cyc;
         end
         chk(conv_start, 1);
      end
   endtask
   task wait_done;
      begin
         for (k = 0; k < 300 && conv_done !== 1'b1; k = k + 1) cyc;
         chk(conv_done, 1);
      end
   endtask
   function [10:0] exp_of(input [3:0] ch);
      case (ch)
         4'hf: exp_of = {3'h5, `MUX_OFFSET};
         4'he: exp_of = {`GAIN_X1, `MUX_COMMON_MODE};
         4'hd: exp_of = {`GAIN_X033, `MUX_SUPPLY};
         default: exp_of = {`GAIN_X1, `MUX_TEMP};
      endcase
   endfunction

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   task t_reset;
      begin
         rd(`ADDR_PRIMARY_CONFIG, {22'h0, `RST_ADC_MODE});
         rd(`ADDR_GAIN_CONFIG, {18'h0, `RST_GAIN, 3'h0});
         rd(`ADDR_CYCLE_INTERVAL, `RST_INTERVAL);
         rd(4'h2, 24'h000000);
         chk(mux_code, `RST_MUX);
         wr(`ADDR_OFFSET_CORR, 24'hfffff6);
         rd(`ADDR_OFFSET_CORR, 24'hfffff6);
      end
   endtask
   task t_supply;
      begin
         wr(`ADDR_GAIN_CONFIG, 24'h000028);
         wr(`ADDR_SCAN_SELECT, 24'h002000);
         wr(`ADDR_PRIMARY_CONFIG, 24'h000003);
         chk(conv_start, 1);
         chk({gain_code, mux_code}, {`GAIN_X033, `MUX_SUPPLY});
         rd(`ADDR_PRIMARY_CONFIG, 24'h000003);
         rd(`ADDR_GAIN_CONFIG, 24'h000028);
         wait_done;
         cyc;
         cyc;
         chk({scan_busy, adc_mode_int}, {1'b0, `ADC_STANDBY});
         rd(`ADDR_PRIMARY_CONFIG, 24'h000002);
      end
   endtask
   task t_gaps;
      for (g = 0; g < 8; g = g + 1) begin
         wr(`ADDR_SCAN_SELECT, {g[2:0], 5'h00, 16'hf000});
         wr(`ADDR_PRIMARY_CONFIG, 24'h000003);
         e = (g == 0) ? 0 : (8 << (g - 1));
         for (c = 15; c >= 12; c = c - 1) begin
            wait_start;
            x = exp_of(c);
            chk({chan_id, gain_code, mux_code}, {c[3:0], x});
            chk(offset_short, c == 15);
            if (c < 15) chk(n >= e && n <= e + 1, 1);
            wait_done;
            cyc;
            n = 0;
            if (c > 12) begin
               x = exp_of(c - 1);
               chk(mux_code, x[7:0]);
               if (g != 0) chk(adc_mode_int, `ADC_STANDBY);
               if (g == 7) begin
                  // The read spends one edge of the gap, so its tick is counted here
                  if (tick === 1'b1) n = 1;
                  rd(`ADDR_PRIMARY_CONFIG, 24'h000003);
               end
            end
         end
         cyc;
         chk(scan_busy, 0);
      end
   endtask
   task t_interval;
      begin
         lat = 8'd200;
         wr(`ADDR_REPEAT_CONFIG, 24'h0000c0);
         wr(`ADDR_SCAN_SELECT, 24'h002000);
         wr(`ADDR_CYCLE_INTERVAL, 24'hffffff);
         rd(`ADDR_CYCLE_INTERVAL, 24'hffffff);
         for (g = 0; g < 4; g = g + 1) begin
            iv = (g == 0) ? 300 : (g == 1) ? 256 : (g == 2) ? 5 : 0;
            wr(`ADDR_CYCLE_INTERVAL, iv[23:0]);
            wr(`ADDR_PRIMARY_CONFIG, 24'h000003);
            wait_start;
            wait_done;
            cyc;
            n = 0;
            w = -1;
            if (iv != 0) chk(adc_mode_int, iv > 256 ? `ADC_SHUTDOWN : `ADC_STANDBY);
            wait_start;
            chk(conv_start, 1);
            chk(n >= iv && n <= iv + 1, 1);
            if (iv > 256) chk(w >= iv - 256 && w <= iv - 255, 1);
            rd(`ADDR_PRIMARY_CONFIG, 24'h000003);
            wr(`ADDR_PRIMARY_CONFIG, 24'h000000);
            cyc;
            chk(scan_busy, 0);
         end
      end
   endtask

   task results;
      begin
         if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
         else $display("RESULT: FAIL");
         $finish;
      end
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   initial begin
      #100000;
      error_cnt = error_cnt + 1;
      results;
   end

   initial begin
      error_cnt = 0;
      total_checks = 0;
      rst_n = 1'b0;
      cfg_wr_en = 1'b0;
      cfg_addr = 4'h0;
      cfg_wr_data = 24'h000000;
      cfg_rd_addr = 4'h0;
      lat = 8'd20;
      repeat (2) @(posedge sys_clk);
      #1;
      rst_n = 1'b1;
      t_reset;
      t_supply;
      t_gaps;
      t_interval;
      results;
   end
endmodule

// File: rtl/scan_sequencer_timing.v
// Scan sequencer: internal-channel overrides, intra-cycle gap and cycle interval timing
//
// Contract
// - Supply channel conversion drives multiplexer code 0x98 for that conversion only.
// - Supply channel conversion forces gain 0.33x whatever the programmed gain.
// - Gain overrides stay internal; the stored gain field reads back as written.
// - Temperature channel conversion drives multiplexer code 0xDE, both sensing diodes.
// - Temperature channel conversion uses unity gain whatever the programmed gain.
// - Offset channel conversion shorts the differential multiplexer output to ground.
// - Common-mode channel drives multiplexer code 0xF8 with unity gain.
// - Gap code 000 gives 0, 001 gives 8, doubling up to 512 periods.
// - Gap select field lives in the scan select register, bits 23 to 21.
// - Gap only between conversions of one cycle, never before first or after last.
// - During a gap the converter idles in standby, mode field still reads 11.
// - Multiplexer moves to the next channel at conversion end, start of the gap.
// - Continuous operation repeats cycles spaced by the interval register at 0x8.
// - Interval is a 24-bit unsigned count of decimation-clock periods.
// - Interval counter loads, counts down to zero, then launches the next cycle.
// - Interval above 256 periods puts the converter in shutdown after each cycle.
// - In shutdown, warm-up starts when the interval counter reaches 256.
// - Interval below 256 periods keeps the converter in standby between cycles.
// - Mode field reads 11 throughout a scan cycle and between cycles.
// - Every scan conversion is one-shot; repeat code 11 loops, others run once.
`timescale 1ns/1ps
`include "scan_seq_regs.vh"

module scan_sequencer_timing (
   input  wire        sys_clk,
   input  wire        rst_n,
   input  wire        cfg_wr_en,
   input  wire [3:0]  cfg_addr,
   input  wire [23:0] cfg_wr_data,
   input  wire [3:0]  cfg_rd_addr,
   output reg  [23:0] cfg_rd_data,
   input  wire        decimation_clock_tick,
   input  wire        conv_done,
   output reg  [7:0]  mux_code,
   output reg  [2:0]  gain_code,
   output reg  [1:0]  adc_mode_int,
   output reg         conv_start,
   output reg         offset_short,
   output reg  [3:0]  chan_id,
   output reg         scan_busy,
   output reg         warmup_active
);

   // ----------------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------------
   localparam [1:0] S_IDLE = 2'h0;
   localparam [1:0] S_CONV = 2'h1;
   localparam [1:0] S_GAP  = 2'h2;
   localparam [1:0] S_WAIT = 2'h3;

   // ----------------------------------------------------------------------
   // Channel decode helpers
   // ----------------------------------------------------------------------
   // Highest enabled channel strictly below lim; bit 4 flags a hit
   function [4:0] pick_next;
      input [15:0] mask;
      input [4:0]  lim;
      integer i;
      begin
         pick_next = 5'h00;
         for (i = 0; i < 16; i = i + 1) begin
            if (mask[i] && (i < lim)) begin
               pick_next = {1'b1, i[3:0]};
            end
         end
      end
   endfunction

   function [7:0] chan_mux;
      input [3:0] idx;
      begin
         case (idx)
            `CH_TEMP:        chan_mux = `MUX_TEMP;
            `CH_SUPPLY:      chan_mux = `MUX_SUPPLY;
            `CH_COMMON_MODE: chan_mux = `MUX_COMMON_MODE;
            `CH_OFFSET:      chan_mux = `MUX_OFFSET;
            default: begin
               if (idx[3]) begin
                  chan_mux = {1'b0, idx[1:0], 1'b0, 1'b0, idx[1:0], 1'b1};
               end else begin
                  chan_mux = {1'b0, idx[2:0], 4'h8};
               end
            end
         endcase
      end
   endfunction

   // Forced gain goes to the converter only; the stored field is untouched
   function [2:0] chan_gain;
      input [3:0] idx;
      input [2:0] prog;
      begin
         case (idx)
            `CH_SUPPLY:      chan_gain = `GAIN_X033;
            `CH_TEMP:        chan_gain = `GAIN_X1;
            `CH_COMMON_MODE: chan_gain = `GAIN_X1;
            default:         chan_gain = prog;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   reg  [1:0]  adc_mode_q;
   reg  [2:0]  gain_q;
   reg  [1:0]  repeat_q;
   reg  [7:0]  mux_q;
   reg  [15:0] scan_mask_q;
   reg  [2:0]  gap_sel_q;
   reg  [23:0] interval_q;
   reg  [23:0] offset_corr_q;
   reg  [1:0]  state_q;
   reg  [1:0]  state_d;
   reg  [3:0]  idx_q;
   reg  [3:0]  idx_d;
   reg  [1:0]  mode_q;
   reg  [1:0]  mode_d;
   reg         warm_q;
   reg         warm_d;
   reg         start_d;
   reg         once_end;
   reg         gap_load;
   reg         intv_load;
   reg  [9:0]  gap_periods;
   wire        gap_zero;
   wire [23:0] intv_count;
   wire        intv_zero;
   wire [4:0]  first_ch;
   wire [4:0]  next_ch;
   wire        wr_primary;
   wire        wr_scan;
   wire        scan_go;
   wire        scan_abort;
   wire        busy_d;
   wire [1:0]  mode_rd;

   assign first_ch = pick_next(scan_mask_q, 5'h10);
   assign next_ch  = pick_next(scan_mask_q, {1'b0, idx_q});
   assign wr_primary = cfg_wr_en && (cfg_addr == `ADDR_PRIMARY_CONFIG);
   assign wr_scan    = cfg_wr_en && (cfg_addr == `ADDR_SCAN_SELECT);

   // Start on a mode write of 11 with channels enabled, or on a scan select
   // write that enables channels while the mode already stands at 11 and the sequencer is not in S_WAIT
   assign scan_go =
      (wr_primary && (cfg_wr_data[`ADC_MODE_LSB +: 2] == `ADC_CONVERT) &&
       (scan_mask_q != 16'h0000)) ||
      (wr_scan && (cfg_wr_data[`SCAN_MASK_MSB:0] != 16'h0000) &&
       (adc_mode_q == `ADC_CONVERT) && (state_q != S_WAIT));
   assign scan_abort =
      (wr_primary && (cfg_wr_data[`ADC_MODE_LSB +: 2] != `ADC_CONVERT)) ||
      (wr_scan && (cfg_wr_data[`SCAN_MASK_MSB:0] == 16'h0000));

   assign busy_d  = (state_d != S_IDLE);
   assign mode_rd = (state_q != S_IDLE) ? `ADC_CONVERT : adc_mode_q;

   // ----------------------------------------------------------------------
   // Gap length decode
   // ----------------------------------------------------------------------
   always @* begin
      if (gap_sel_q == 3'h0) begin
         gap_periods = 10'h000;
      end else begin
         gap_periods = `GAP_BASE_PERIODS << gap_sel_q;
      end
   end

   // ----------------------------------------------------------------------
   // Period counters
   // ----------------------------------------------------------------------
   tick_down_counter #(
      .W (10)
   ) u_gap_counter (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .load     (gap_load),
      .load_val (gap_periods),
      .tick     (decimation_clock_tick),
      .count    (),
      .zero     (gap_zero)
   );

   tick_down_counter #(
      .W (24)
   ) u_interval_counter (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .load     (intv_load),
      .load_val (interval_q),
      .tick     (decimation_clock_tick),
      .count    (intv_count),
      .zero     (intv_zero)
   );

   // ----------------------------------------------------------------------
   // Sequencer next state
   // ----------------------------------------------------------------------
   always @* begin
      state_d   = state_q;
      idx_d     = idx_q;
      mode_d    = mode_q;
      warm_d    = warm_q;
      start_d   = 1'b0;
      once_end  = 1'b0;
      gap_load  = 1'b0;
      intv_load = 1'b0;
      if (scan_abort) begin
         state_d = S_IDLE;
         mode_d  = `ADC_STANDBY;
         warm_d  = 1'b0;
      end else if (scan_go) begin
         state_d = S_CONV;
         idx_d   = first_ch[3:0];
         mode_d  = `ADC_CONVERT;
         warm_d  = 1'b0;
         start_d = 1'b1;
      end else begin
         case (state_q)
            S_CONV: begin
               if (conv_done) begin
                  if (next_ch[4]) begin
                     idx_d = next_ch[3:0];
                     if (gap_sel_q != 3'h0) begin
                        gap_load = 1'b1;
                        state_d  = S_GAP;
                        mode_d   = `ADC_STANDBY;
                     end else begin
                        start_d = 1'b1;
                     end
                  end else if (repeat_q == `REPEAT_CONTINUOUS) begin
                     intv_load = 1'b1;
                     state_d   = S_WAIT;
                     idx_d     = first_ch[3:0];
                     if (interval_q > `WARMUP_PERIODS) begin
                        mode_d = `ADC_SHUTDOWN;
                     end else begin
                        mode_d = `ADC_STANDBY;
                     end
                  end else begin
                     once_end = 1'b1;
                     state_d  = S_IDLE;
                     mode_d   = `ADC_STANDBY;
                  end
               end
            end
            S_GAP: begin
               if (gap_zero) begin
                  state_d = S_CONV;
                  mode_d  = `ADC_CONVERT;
                  start_d = 1'b1;
               end
            end
            S_WAIT: begin
               if (intv_zero) begin
                  state_d = S_CONV;
                  mode_d  = `ADC_CONVERT;
                  warm_d  = 1'b0;
                  start_d = 1'b1;
               end else if ((intv_count == `WARMUP_PERIODS) && (mode_q == `ADC_SHUTDOWN)) begin
                  mode_d = `ADC_STANDBY;
                  warm_d = 1'b1;
               end
            end
            default: begin
               state_d = S_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Sequencer state registers
   // ----------------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         state_q <= S_IDLE;
         idx_q   <= 4'h0;
         mode_q  <= `ADC_STANDBY;
         warm_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         idx_q   <= idx_d;
         mode_q  <= mode_d;
         warm_q  <= warm_d;
      end
   end

   // ----------------------------------------------------------------------
   // Converter-facing outputs
   // ----------------------------------------------------------------------
   // Driven from the next-state values so the multiplexer moves on the
   // very edge that closes a conversion, giving the gap its full settling time
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         mux_code      <= `RST_MUX;
         gain_code     <= `RST_GAIN;
         adc_mode_int  <= `RST_ADC_MODE;
         conv_start    <= 1'b0;
         offset_short  <= 1'b0;
         chan_id       <= 4'h0;
         scan_busy     <= 1'b0;
         warmup_active <= 1'b0;
      end else begin
         conv_start    <= start_d;
         scan_busy     <= busy_d;
         warmup_active <= warm_d;
         if (busy_d) begin
            mux_code     <= chan_mux(idx_d);
            gain_code    <= chan_gain(idx_d, gain_q);
            adc_mode_int <= mode_d;
            offset_short <= (idx_d == `CH_OFFSET);
            chan_id      <= idx_d;
         end else begin
            mux_code     <= mux_q;
            gain_code    <= gain_q;
            adc_mode_int <= (scan_mask_q != 16'h0000) ? mode_d : adc_mode_q;
            offset_short <= 1'b0;
            chan_id      <= 4'h0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------------
   // A host mode write in the same cycle as the one-shot end keeps the
   // host value: the host command is the newer intent
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         adc_mode_q    <= `RST_ADC_MODE;
         gain_q        <= `RST_GAIN;
         repeat_q      <= `RST_REPEAT;
         mux_q         <= `RST_MUX;
         scan_mask_q   <= `RST_SCAN_MASK;
         gap_sel_q     <= `RST_GAP_SEL;
         interval_q    <= `RST_INTERVAL;
         offset_corr_q <= `RST_OFFSET_CORR;
      end else begin
         if (wr_primary) begin
            adc_mode_q <= cfg_wr_data[`ADC_MODE_LSB +: 2];
         end else if (once_end) begin
            adc_mode_q <= `ADC_STANDBY;
         end
         if (cfg_wr_en) begin
            case (cfg_addr)
               `ADDR_GAIN_CONFIG:    gain_q        <= cfg_wr_data[`GAIN_LSB +: 3];
               `ADDR_REPEAT_CONFIG:  repeat_q      <= cfg_wr_data[`REPEAT_LSB +: 2];
               `ADDR_MUX_SELECT:     mux_q         <= cfg_wr_data[7:0];
               `ADDR_CYCLE_INTERVAL: interval_q    <= cfg_wr_data;
               `ADDR_OFFSET_CORR:    offset_corr_q <= cfg_wr_data;
               `ADDR_SCAN_SELECT: begin
                  scan_mask_q <= cfg_wr_data[`SCAN_MASK_MSB:0];
                  gap_sel_q   <= cfg_wr_data[`GAP_SEL_MSB:`GAP_SEL_LSB];
               end
               default: begin
                  scan_mask_q <= scan_mask_q;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // Register read-back
   // ----------------------------------------------------------------------
   // Narrow fields sit at their positions; all other bits read as zero
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         cfg_rd_data <= 24'h000000;
      end else begin
         case (cfg_rd_addr)
            `ADDR_PRIMARY_CONFIG: cfg_rd_data <= {22'h000000, mode_rd};
            `ADDR_GAIN_CONFIG:    cfg_rd_data <= {18'h00000, gain_q, 3'h0};
            `ADDR_REPEAT_CONFIG:  cfg_rd_data <= {16'h0000, repeat_q, 6'h00};
            `ADDR_MUX_SELECT:     cfg_rd_data <= {16'h0000, mux_q};
            `ADDR_SCAN_SELECT:    cfg_rd_data <= {gap_sel_q, 5'h00, scan_mask_q};
            `ADDR_CYCLE_INTERVAL: cfg_rd_data <= interval_q;
            `ADDR_OFFSET_CORR:    cfg_rd_data <= offset_corr_q;
            default:              cfg_rd_data <= 24'h000000;
         endcase
      end
   end

endmodule

// File: rtl/tick_down_counter.v
// Loadable down-counter that steps once per decimation-clock tick
`timescale 1ns/1ps

module tick_down_counter #(
   parameter W = 24
) (
   input  wire         sys_clk,
   input  wire         rst_n,
   input  wire         load,
   input  wire [W-1:0] load_val,
   input  wire         tick,
   output wire [W-1:0] count,
   output wire         zero
);

   reg [W-1:0] count_q;

   // ----------------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------------
   // A load wins over a tick so a fresh period never loses its first step
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         count_q <= {W{1'b0}};
      end else if (load) begin
         count_q <= load_val;
      end else if (tick && (count_q != {W{1'b0}})) begin
         count_q <= count_q - {{(W-1){1'b0}}, 1'b1};
      end
   end

   assign count = count_q;
   assign zero  = (count_q == {W{1'b0}});

endmodule

// File: shared/scan_seq_regs.vh
// Register offsets, field positions, codes and timing counts for the scan sequencer
`ifndef SCAN_SEQ_REGS_VH
`define SCAN_SEQ_REGS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ADDR_PRIMARY_CONFIG   4'h1
`define ADDR_GAIN_CONFIG      4'h3
`define ADDR_REPEAT_CONFIG    4'h4
`define ADDR_MUX_SELECT       4'h6
`define ADDR_SCAN_SELECT      4'h7
`define ADDR_CYCLE_INTERVAL   4'h8
`define ADDR_OFFSET_CORR      4'h9

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ADC_MODE_LSB          0
`define GAIN_LSB              3
`define REPEAT_LSB            6
`define GAP_SEL_LSB           21
`define GAP_SEL_MSB           23
`define SCAN_MASK_MSB         15

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_ADC_MODE          2'h0
`define RST_GAIN              3'h1
`define RST_REPEAT            2'h0
`define RST_MUX               8'h01
`define RST_SCAN_MASK         16'h0000
`define RST_GAP_SEL           3'h0
`define RST_INTERVAL          24'h000000
`define RST_OFFSET_CORR       24'h000000

// ----------------------------------------------------------------------
// Converter state, repeat and gain codes
// ----------------------------------------------------------------------
`define ADC_SHUTDOWN          2'h0
`define ADC_STANDBY           2'h2
`define ADC_CONVERT           2'h3
`define REPEAT_CONTINUOUS     2'h3
`define GAIN_X033             3'h0
`define GAIN_X1               3'h1

// ----------------------------------------------------------------------
// Internal channel indices and forced multiplexer codes
// ----------------------------------------------------------------------
`define CH_TEMP               4'hc
`define CH_SUPPLY             4'hd
`define CH_COMMON_MODE        4'he
`define CH_OFFSET             4'hf
`define MUX_TEMP              8'hde
`define MUX_SUPPLY            8'h98
`define MUX_COMMON_MODE       8'hf8
`define MUX_OFFSET            8'h88

// ----------------------------------------------------------------------
// Timing counts in decimation-clock periods
// ----------------------------------------------------------------------
`define WARMUP_PERIODS        24'h000100
`define GAP_BASE_PERIODS      10'h004

`endif
